// *** video_timing_defines.svh ***
// timing constants for the dual mode video sync generator
`ifndef VIDEO_TIMING_DEFINES_SVH
`define VIDEO_TIMING_DEFINES_SVH

// ----------------------------------------------------------------
// system clock and pixel rates
// ----------------------------------------------------------------
`define CLK_MHZ 40
`define VGA_PIX_MHZ 25
`define HR_PIX_MHZ 80
// vga pixel enable: phase accumulator adds 5/8 of a pixel per clock
`define VGA_ACC_STEP 4'h5
// high resolution: two pixels per system clock
`define HR_PIX_PER_CLK 2

// ----------------------------------------------------------------
// high resolution geometry and times (ns)
// ----------------------------------------------------------------
`define HR_H_ACTIVE_PIX 1984
`define HR_V_ACTIVE_LINES 512
`define HR_HFP_NS 1125
`define HR_HSYNC_NS 3000
`define HR_HBP_NS 1375
`define HR_VFP_NS 37000
`define HR_VSYNC_NS 73000
`define HR_VBP_NS 442000

// ----------------------------------------------------------------
// vga geometry and times (ns)
// ----------------------------------------------------------------
`define VGA_H_ACTIVE_PIX 640
`define VGA_V_ACTIVE_LINES 480
`define VGA_HFP_NS 640
`define VGA_HSYNC_NS 3520
`define VGA_HBP_NS 1920
`define VGA_VFP_NS 349000
`define VGA_VSYNC_NS 63000
`define VGA_VBP_NS 1019000

// ----------------------------------------------------------------
// derived counts: least times round up
// ----------------------------------------------------------------
`define NS_UP(ns, mhz) (((ns) * (mhz) + 999) / 1000)
`define DIV_UP(a, b) (((a) + (b) - 1) / (b))

// high resolution horizontal counts in system clocks (pixel pairs)
`define HR_HACT_CNT (`HR_H_ACTIVE_PIX / `HR_PIX_PER_CLK)
`define HR_HFP_CNT `NS_UP(`HR_HFP_NS, `CLK_MHZ)
`define HR_HSYNC_CNT `NS_UP(`HR_HSYNC_NS, `CLK_MHZ)
`define HR_HBP_CNT `NS_UP(`HR_HBP_NS, `CLK_MHZ)
`define HR_LINE_CNT (`HR_HACT_CNT + `HR_HFP_CNT + `HR_HSYNC_CNT + `HR_HBP_CNT)
`define HR_LINE_NS (`HR_LINE_CNT * 1000 / `CLK_MHZ)
`define HR_VFP_CNT `DIV_UP(`HR_VFP_NS, `HR_LINE_NS)
`define HR_VSYNC_CNT `DIV_UP(`HR_VSYNC_NS, `HR_LINE_NS)
`define HR_VBP_CNT `DIV_UP(`HR_VBP_NS, `HR_LINE_NS)

// vga horizontal counts in 25 MHz pixels
`define VGA_HACT_CNT `VGA_H_ACTIVE_PIX
`define VGA_HFP_CNT `NS_UP(`VGA_HFP_NS, `VGA_PIX_MHZ)
`define VGA_HSYNC_CNT `NS_UP(`VGA_HSYNC_NS, `VGA_PIX_MHZ)
`define VGA_HBP_CNT `NS_UP(`VGA_HBP_NS, `VGA_PIX_MHZ)
`define VGA_LINE_CNT (`VGA_HACT_CNT + `VGA_HFP_CNT + `VGA_HSYNC_CNT + `VGA_HBP_CNT)
`define VGA_LINE_NS (`VGA_LINE_CNT * 1000 / `VGA_PIX_MHZ)
`define VGA_VFP_CNT `DIV_UP(`VGA_VFP_NS, `VGA_LINE_NS)
`define VGA_VSYNC_CNT `DIV_UP(`VGA_VSYNC_NS, `VGA_LINE_NS)
`define VGA_VBP_CNT `DIV_UP(`VGA_VBP_NS, `VGA_LINE_NS)

// ----------------------------------------------------------------
// monitor id codes that select vga
// ----------------------------------------------------------------
`define MON_ID_VGA_A 3'h3
`define MON_ID_VGA_B 3'h5

`endif

// *** video_timing_pkg.sv ***
// types for the dual mode video sync generator
`default_nettype none

package video_timing_pkg;

   // ----------------------------------------------------------------
   // modes and phases
   // ----------------------------------------------------------------
   typedef enum logic {MODE_HIRES, MODE_VGA} mode_e;
   typedef enum logic [1:0] {PH_ACTIVE, PH_FRONT, PH_SYNC, PH_BACK} phase_e;

   // ----------------------------------------------------------------
   // output bundle
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hsync_n;
      logic vsync_n;
      logic de;
      logic pix_en;
      logic [15:0] pix;
      logic line_start;
      logic frame_start;
      logic hires;
      logic [10:0] xpos;
      logic [9:0] ypos;
   } video_out_s;

   // ----------------------------------------------------------------
   // complete block state
   // ----------------------------------------------------------------
   typedef struct packed {
      mode_e mode;
      phase_e hph;
      phase_e vph;
      logic [10:0] hcnt;
      logic [10:0] vcnt;
      logic [2:0] acc;
      logic started;
      video_out_s out;
   } state_s;

endpackage

`default_nettype wire

// *** video_sync_gen.sv ***
// dual mode horizontal/vertical sync and active video timing generator
// What this block does
// RULE1: hi-res mode gives 1984 active pixels per line and 512 visible lines.
// RULE2: hi-res frames repeat near 62 Hz, lines near 33.0 kHz.
// RULE3: hi-res pixel rate at most 80 MHz, one pixel per dot period.
// RULE4: both modes drive horizontal and vertical sync active low.
// RULE5: hi-res front porch 1.125 us horizontal, 0.037 ms vertical.
// RULE6: hi-res sync pulse 3.000 us horizontal, 0.073 ms vertical.
// RULE7: hi-res back porch 1.375 us horizontal, 0.442 ms vertical.
// RULE8: vga mode gives 640 active pixels per line and 480 visible lines.
// RULE9: vga frames repeat near 60 Hz, lines near 31.6 kHz.
// RULE10: vga pixel rate at most 25 MHz, one pixel per dot period.
// RULE11: vga front porch 0.640 us horizontal, 0.349 ms vertical.
// RULE12: vga sync pulse 3.520 us horizontal, 0.063 ms vertical.
// RULE13: vga back porch 1.920 us horizontal, 1.019 ms vertical.
// RULE14: id codes 011 or 101 pick vga; any other code, all ones included, hi-res.
// RULE15: vga uses a 25 MHz pixel rate, hi-res 40 MHz doubled to 80.
// RULE16: order is active, front porch, sync, back porch; pixels blanked outside active.
// RULE17: reset restarts at active video with syncs high; mode changes at frame boundary.
`include "video_timing_defines.svh"
`default_nettype none

module video_sync_gen (
   input wire logic clk,
   input wire logic rstn,
   input wire logic monitor_id_bit0,
   input wire logic monitor_id_bit1,
   input wire logic monitor_id_bit2,
   input wire logic [15:0] pixel_in,
   output video_timing_pkg::video_out_s video_out
);

   // ----------------------------------------------------------------
   // phase lengths
   // ----------------------------------------------------------------
   function automatic logic [10:0] h_len(input logic hires, input video_timing_pkg::phase_e ph);
      logic [10:0] len;
      len = 11'h1;
      if (hires) begin
         unique case (ph)
            video_timing_pkg::PH_ACTIVE: len = 11'(`HR_HACT_CNT); // [RULE1] [RULE3]
            video_timing_pkg::PH_FRONT: len = 11'(`HR_HFP_CNT); // [RULE5]
            video_timing_pkg::PH_SYNC: len = 11'(`HR_HSYNC_CNT); // [RULE6]
            video_timing_pkg::PH_BACK: len = 11'(`HR_HBP_CNT); // [RULE7]
         endcase
      end else begin
         unique case (ph)
            video_timing_pkg::PH_ACTIVE: len = 11'(`VGA_HACT_CNT); // [RULE8]
            video_timing_pkg::PH_FRONT: len = 11'(`VGA_HFP_CNT); // [RULE11]
            video_timing_pkg::PH_SYNC: len = 11'(`VGA_HSYNC_CNT); // [RULE12]
            video_timing_pkg::PH_BACK: len = 11'(`VGA_HBP_CNT); // [RULE13]
         endcase
      end
      return len;
   endfunction

   function automatic logic [10:0] v_len(input logic hires, input video_timing_pkg::phase_e ph);
      logic [10:0] len;
      len = 11'h1;
      if (hires) begin
         unique case (ph)
            video_timing_pkg::PH_ACTIVE: len = 11'(`HR_V_ACTIVE_LINES); // [RULE1]
            video_timing_pkg::PH_FRONT: len = 11'(`HR_VFP_CNT); // [RULE5]
            video_timing_pkg::PH_SYNC: len = 11'(`HR_VSYNC_CNT); // [RULE6]
            video_timing_pkg::PH_BACK: len = 11'(`HR_VBP_CNT); // [RULE7]
         endcase
      end else begin
         unique case (ph)
            video_timing_pkg::PH_ACTIVE: len = 11'(`VGA_V_ACTIVE_LINES); // [RULE8]
            video_timing_pkg::PH_FRONT: len = 11'(`VGA_VFP_CNT); // [RULE11]
            video_timing_pkg::PH_SYNC: len = 11'(`VGA_VSYNC_CNT); // [RULE12]
            video_timing_pkg::PH_BACK: len = 11'(`VGA_VBP_CNT); // [RULE13]
         endcase
      end
      return len;
   endfunction

   // fixed phase order, wraps back to active
   function automatic video_timing_pkg::phase_e next_ph(input video_timing_pkg::phase_e ph);
      video_timing_pkg::phase_e n;
      n = video_timing_pkg::PH_ACTIVE;
      unique case (ph)
         video_timing_pkg::PH_ACTIVE: n = video_timing_pkg::PH_FRONT; // [RULE16]
         video_timing_pkg::PH_FRONT: n = video_timing_pkg::PH_SYNC; // [RULE16]
         video_timing_pkg::PH_SYNC: n = video_timing_pkg::PH_BACK; // [RULE16]
         video_timing_pkg::PH_BACK: n = video_timing_pkg::PH_ACTIVE; // [RULE16]
      endcase
      return n;
   endfunction

   // ----------------------------------------------------------------
   // mode decode from monitor id
   // ----------------------------------------------------------------
   logic [2:0] mon_id;
   video_timing_pkg::mode_e id_mode;

   assign mon_id = {monitor_id_bit2, monitor_id_bit1, monitor_id_bit0};
   assign id_mode = (mon_id == `MON_ID_VGA_A || mon_id == `MON_ID_VGA_B) ?
                    video_timing_pkg::MODE_VGA : video_timing_pkg::MODE_HIRES; // [RULE14]

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   video_timing_pkg::state_s st_r;
   video_timing_pkg::state_s st_nxt;
   logic hires;
   logic [3:0] acc_sum;
   logic tick;

   assign hires = (st_r.mode == video_timing_pkg::MODE_HIRES);
   // vga dot enable averages 25 MHz from the 40 MHz clock
   assign acc_sum = {1'b0, st_r.acc} + `VGA_ACC_STEP; // [RULE15]
   // hi-res advances one pixel pair per clock, i.e. 80 MHz dots
   assign tick = st_r.started && (hires || acc_sum[3]); // [RULE3] [RULE10] [RULE15]

   always_comb begin
      st_nxt = st_r;
      st_nxt.acc = hires ? 3'h0 : acc_sum[2:0];
      st_nxt.out.pix_en = 1'b0;
      st_nxt.out.line_start = 1'b0;
      st_nxt.out.frame_start = 1'b0;
      if (!st_r.started) begin
         // release of reset counts as a frame boundary
         st_nxt.started = 1'b1;
         st_nxt.mode = id_mode; // [RULE14] [RULE17]
         st_nxt.out.frame_start = 1'b1;
         st_nxt.out.line_start = 1'b1;
      end else if (tick) begin
         st_nxt.out.pix_en = 1'b1;
         if (st_r.hcnt == h_len(hires, st_r.hph) - 11'h1) begin
            st_nxt.hcnt = 11'h0;
            st_nxt.hph = next_ph(st_r.hph); // [RULE16]
            if (st_r.hph == video_timing_pkg::PH_BACK) begin
               // end of line: advance vertical timing
               st_nxt.out.line_start = 1'b1; // [RULE2] [RULE9]
               if (st_r.vcnt == v_len(hires, st_r.vph) - 11'h1) begin
                  st_nxt.vcnt = 11'h0;
                  st_nxt.vph = next_ph(st_r.vph); // [RULE16]
                  if (st_r.vph == video_timing_pkg::PH_BACK) begin
                     st_nxt.out.frame_start = 1'b1;
                     st_nxt.mode = id_mode; // [RULE17] [RULE14]
                  end
               end else begin
                  st_nxt.vcnt = st_r.vcnt + 11'h1;
               end
            end
         end else begin
            st_nxt.hcnt = st_r.hcnt + 11'h1;
         end
      end
      // outputs follow the next phases so they leave the flops aligned
      st_nxt.out.hsync_n = (st_nxt.hph != video_timing_pkg::PH_SYNC); // [RULE4]
      st_nxt.out.vsync_n = (st_nxt.vph != video_timing_pkg::PH_SYNC); // [RULE4]
      st_nxt.out.de = (st_nxt.hph == video_timing_pkg::PH_ACTIVE) &&
                      (st_nxt.vph == video_timing_pkg::PH_ACTIVE); // [RULE16]
      st_nxt.out.hires = (st_nxt.mode == video_timing_pkg::MODE_HIRES);
      st_nxt.out.xpos = st_nxt.out.de ? st_nxt.hcnt : 11'h0;
      st_nxt.out.ypos = (st_nxt.vph == video_timing_pkg::PH_ACTIVE) ? st_nxt.vcnt[9:0] : 10'h0;
      if (!st_nxt.out.de) begin
         st_nxt.out.pix = 16'h0; // [RULE16]
      end else if (st_nxt.out.hires) begin
         st_nxt.out.pix = pixel_in; // [RULE3]
      end else begin
         st_nxt.out.pix = {8'h00, pixel_in[7:0]}; // [RULE10]
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r.mode <= video_timing_pkg::MODE_HIRES;
         st_r.hph <= video_timing_pkg::PH_ACTIVE; // [RULE17]
         st_r.vph <= video_timing_pkg::PH_ACTIVE; // [RULE17]
         st_r.hcnt <= 11'h0;
         st_r.vcnt <= 11'h0;
         st_r.acc <= 3'h0;
         st_r.started <= 1'b0;
         st_r.out.hsync_n <= 1'b1; // [RULE17]
         st_r.out.vsync_n <= 1'b1; // [RULE17]
         st_r.out.de <= 1'b0;
         st_r.out.pix_en <= 1'b0;
         st_r.out.pix <= 16'h0;
         st_r.out.line_start <= 1'b0;
         st_r.out.frame_start <= 1'b0;
         st_r.out.hires <= 1'b1;
         st_r.out.xpos <= 11'h0;
         st_r.out.ypos <= 10'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign video_out = st_r.out;

endmodule

`default_nettype wire

// *** sync_gen_chk.sv ***
// assertion checker for the dual mode sync generator
`default_nettype none

module sync_gen_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic monitor_id_bit0,
   input wire logic monitor_id_bit1,
   input wire logic monitor_id_bit2,
   input wire logic [15:0] pixel_in,
   input wire video_timing_pkg::video_out_s video_out
);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   video_timing_pkg::video_out_s vo;
   logic [2:0] id;
   logic [7:0] low_cnt_r;
   assign vo = video_out;
   assign id = {monitor_id_bit2, monitor_id_bit1, monitor_id_bit0};
   // counts samples with horizontal sync low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) low_cnt_r <= 8'h00;
      else if (!vo.hsync_n) low_cnt_r <= low_cnt_r + 8'h01;
      else low_cnt_r <= 8'h00;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_reset_start: assert property ($rose(rstn) |=> vo.frame_start && vo.line_start && vo.de
      && vo.hsync_n && vo.vsync_n) else $error("bad state after reset release");
   a_blank_pix: assert property (!vo.de |-> vo.pix == 16'h0000)
      else $error("pixel not blanked");
   a_sync_active: assert property (vo.de |-> vo.hsync_n && vo.vsync_n)
      else $error("sync asserted during active video");
   a_line_de: assert property ($rose(vo.de) |-> vo.line_start)
      else $error("active video began without line start");
   a_hires_dot: assert property (vo.hires && !vo.frame_start && $past(rstn) |-> vo.pix_en)
      else $error("hires dot enable missing");
   a_vga_rate: assert property (!vo.hires && vo.pix_en && $past(vo.pix_en) |=> !vo.pix_en)
      else $error("vga dot rate too high");
   a_vga_byte: assert property (!vo.hires |-> vo.pix[15:8] == 8'h00)
      else $error("vga high byte not zero");
   a_pix_pass: assert property (vo.hires && vo.de && !vo.frame_start |->
      vo.pix == $past(pixel_in)) else $error("pixel data not passed");
   a_hires_fp: assert property (vo.hires && $fell(vo.de) |-> ##44 vo.hsync_n ##1 !vo.hsync_n)
      else $error("hires front porch wrong");
   a_hires_sync: assert property (vo.hires && $rose(vo.hsync_n) |-> low_cnt_r == 8'h78)
      else $error("hires sync width wrong");
   a_hires_bp: assert property (vo.hires && $rose(vo.hsync_n) |->
      ##54 !vo.line_start ##1 vo.line_start) else $error("hires back porch wrong");
   a_mode_hold: assert property (!vo.frame_start |-> $stable(vo.hires))
      else $error("mode changed inside a frame");
   a_id_select: assert property (vo.frame_start |->
      vo.hires == !($past(id) == 3'h3 || $past(id) == 3'h5)) else $error("wrong mode for id");
   c_hires_line: cover property (vo.hires && vo.line_start);
   c_vga_line: cover property (!vo.hires && vo.line_start);
   c_vga_sync: cover property (!vo.hires && $rose(vo.hsync_n));
endmodule

bind video_sync_gen sync_gen_chk chk (.clk(clk), .rstn(rstn), .monitor_id_bit0(monitor_id_bit0),
   .monitor_id_bit1(monitor_id_bit1), .monitor_id_bit2(monitor_id_bit2),
   .pixel_in(pixel_in), .video_out(video_out));

`default_nettype wire

// *** display_model.sv ***
// display model presenting a monitor id code to the sync generator
`default_nettype none

module display_model (
   input wire logic attached,
   input wire logic [2:0] id_code,
   output logic monitor_id_bit0,
   output logic monitor_id_bit1,
   output logic monitor_id_bit2
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-ups give all ones with no display attached
   assign {monitor_id_bit2, monitor_id_bit1, monitor_id_bit0} = attached ? id_code : 3'h7;
endmodule

`default_nettype wire

// *** testbench.sv ***
// self-checking testbench for the dual mode sync generator
`default_nettype none
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, attached, id0, id1, id2;
   logic [2:0] id_code;
   logic [15:0] pixel_in;
   video_timing_pkg::video_out_s video_out;
   int num_errors = 0;
   int samples_checked = 0;
   int c [4];

   video_sync_gen DUT (.clk(clk), .rstn(rstn), .monitor_id_bit0(id0), .monitor_id_bit1(id1),
      .monitor_id_bit2(id2), .pixel_in(pixel_in), .video_out(video_out));
   display_model monitor (.attached(attached), .id_code(id_code), .monitor_id_bit0(id0),
      .monitor_id_bit1(id1), .monitor_id_bit2(id2));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) pixel_in <= pixel_in + 16'h0123;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input logic [2:0] code, input logic att);
      @(negedge clk);
      rstn = 1'b0;
      id_code = code;
      attached = att;
      repeat (2) @(negedge clk);
      `CHECK("reset syncs", 2'b11, {video_out.hsync_n, video_out.vsync_n})
      rstn = 1'b1;
   endtask
   task automatic wait_line();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (video_out.line_start !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         num_errors++;
         stop_test();
      end
   endtask
   // counts dot ticks of each phase over one whole line
   task automatic line_phases();
      int ph, n;
      c = '{0, 0, 0, 0};
      ph = 0;
      n = 0;
      wait_line();
      wait_line();
      do begin
         ph = video_out.de ? 0 : (!video_out.hsync_n ? 2 : (ph >= 2 ? 3 : 1));
         if (video_out.pix_en === 1'b1) c[ph]++;
         @(negedge clk);
         n++;
      end while (video_out.line_start !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         num_errors++;
         stop_test();
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_hires_line();
      do_reset(3'h7, 1'b1);
      line_phases();
      `CHECK("hires mode", 1'b1, video_out.hires)
      `CHECK("hires active", 992, c[0])
      `CHECK("hires front porch", 45, c[1])
      `CHECK("hires sync", 120, c[2])
      `CHECK("hires back porch", 55, c[3])
      `CHECK("hires line number", 10'h2, video_out.ypos)
      repeat (991) @(negedge clk);
      `CHECK("hires last pair", 11'h3df, video_out.xpos)
      @(negedge clk);
      `CHECK("hires active end", 1'b0, video_out.de)
   endtask
   task automatic test_vga_line();
      do_reset(3'h3, 1'b1);
      line_phases();
      `CHECK("vga mode", 1'b0, video_out.hires)
      `CHECK("vga active", 640, c[0])
      `CHECK("vga front porch", 16, c[1])
      `CHECK("vga sync", 88, c[2])
      `CHECK("vga back porch", 48, c[3])
   endtask
   task automatic test_id_codes();
      for (int i = 0; i < 8; i++) begin
         do_reset(3'(i), 1'b1);
         wait_line();
         `CHECK("mode for id", !(i == 3 || i == 5), video_out.hires)
      end
      do_reset(3'h3, 1'b0);
      wait_line();
      `CHECK("mode without display", 1'b1, video_out.hires)
   endtask
   task automatic test_start_and_hold();
      do_reset(3'h5, 1'b1);
      @(negedge clk);
      `CHECK("start of frame", 4'b1111,
         {video_out.hsync_n, video_out.vsync_n, video_out.de, video_out.frame_start})
      `CHECK("start position", 21'h0, {video_out.xpos, video_out.ypos})
      wait_line();
      id_code = 3'h7;
      repeat (3) wait_line();
      `CHECK("mode held in frame", 1'b0, video_out.hires)
      `CHECK("line count in frame", 10'h4, video_out.ypos)
   endtask

   initial begin
      rstn = 1'b0;
      attached = 1'b1;
      id_code = 3'h7;
      pixel_in = 16'h0000;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      test_hires_line();
      test_vga_line();
      test_id_codes();
      test_start_and_hold();
      stop_test();
   end
endmodule

`default_nettype wire
